/* rtl/amsd_defs.svh */
// constants for the mode and settling delay control block
// assumes a 25 MHz modulator clock
`ifndef AMSD_DEFS_SVH
`define AMSD_DEFS_SVH

`define AMSD_CLK_MHZ 25
// delay settings in microseconds
`define AMSD_DLY0_US 0
`define AMSD_DLY1_US 4
`define AMSD_DLY2_US 16
`define AMSD_DLY3_US 40
`define AMSD_DLY4_US 100
`define AMSD_DLY5_US 200
`define AMSD_DLY6_US 500
`define AMSD_DLY7_US 1000
`define AMSD_CNT_W 15
`define AMSD_RESERVED_MODE 3'h5
`define AMSD_KIND_RST 3'h0

`endif

/* rtl/amsd_pkg.sv */
// types for the mode and settling delay control block
// assumes nothing beyond the defs header
package amsd_pkg;
   typedef enum logic [2:0] {
      AMSD_CONT = 3'b000,
      AMSD_SINGLE = 3'b001,
      AMSD_STANDBY = 3'b010,
      AMSD_PDOWN = 3'b011,
      AMSD_CAL_IOFF = 3'b100,
      AMSD_RSVD = 3'b101,
      AMSD_CAL_SOFF = 3'b110,
      AMSD_CAL_SGAIN = 3'b111
   } amsd_mode_type;

   typedef enum logic [1:0] {
      AMSD_ST_IDLE = 2'b00,
      AMSD_ST_SETTLE = 2'b01,
      AMSD_ST_RUN = 2'b10
   } amsd_state_type;
endpackage

/* rtl/amsd_delay_lut.sv */
// delay code to cycle count decode
// assumes the clock rate of the defs header
`timescale 1ns/10ps
`include "amsd_defs.svh"

module amsd_delay_lut #(
   parameter int CNT_W = `AMSD_CNT_W
) (
   input wire logic [2:0] delay_code,
   output logic [CNT_W-1:0] delay_cycles
);
   localparam int C1 = `AMSD_DLY1_US * `AMSD_CLK_MHZ;
   localparam int C2 = `AMSD_DLY2_US * `AMSD_CLK_MHZ;
   localparam int C3 = `AMSD_DLY3_US * `AMSD_CLK_MHZ;
   localparam int C4 = `AMSD_DLY4_US * `AMSD_CLK_MHZ;
   localparam int C5 = `AMSD_DLY5_US * `AMSD_CLK_MHZ;
   localparam int C6 = `AMSD_DLY6_US * `AMSD_CLK_MHZ;
   localparam int C7 = `AMSD_DLY7_US * `AMSD_CLK_MHZ;

   always_comb begin
      case (delay_code)
         3'h0: delay_cycles = CNT_W'(`AMSD_DLY0_US);
         3'h1: delay_cycles = CNT_W'(C1);
         3'h2: delay_cycles = CNT_W'(C2);
         3'h3: delay_cycles = CNT_W'(C3);
         3'h4: delay_cycles = CNT_W'(C4);
         3'h5: delay_cycles = CNT_W'(C5);
         3'h6: delay_cycles = CNT_W'(C6);
         default: delay_cycles = CNT_W'(C7);
      endcase
   end
endmodule

/* rtl/amsd_ctrl.sv */
// mode decode and post-switch settling delay control
// assumes register fields arrive already decoded from the serial port
//
// Function
// - delay field codes wait of 0,4,16,40,100,200,500 us or 1 ms
// - after each channel change, processing waits for the full delay
// - mode 000 continuous, 001 single then stop, 010 standby, 011 power-down
// - writing 100, 110 or 111 starts offset or gain calibration
`timescale 1ns/10ps
`include "amsd_defs.svh"

module amsd_ctrl #(
   parameter int CNT_W = `AMSD_CNT_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] delay_code,
   input wire logic rsvd_bit,
   input wire logic [2:0] mode_code,
   input wire logic mode_wr,
   input wire logic chan_switch,
   input wire logic conv_done,
   input wire logic cal_done,
   output logic process_en,
   output logic settling,
   output logic cal_start,
   output logic [2:0] cal_kind,
   output logic cal_busy,
   output logic standby,
   output logic power_down,
   output logic [2:0] active_mode
);
   ////////////////////////////////////////////////////////////////////
   // settle state
   amsd_pkg::amsd_state_type st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] dly_cycles;
   logic settle_q, settle_d;

   // mode state
   amsd_pkg::amsd_mode_type mode_q, mode_d;
   logic stop_q, stop_d;
   logic stby_q, stby_d;
   logic pdn_q, pdn_d;
   logic mode_is_cal;
   logic mode_is_rsvd;
   logic mode_take;
   logic single_end;

   // calibration state
   logic cal_q, cal_d;
   logic start_q, start_d;
   logic [2:0] kind_q, kind_d;
   logic cal_end;

   amsd_delay_lut #(.CNT_W(CNT_W)) u_lut (
      .delay_code(delay_code),
      .delay_cycles(dly_cycles)
   );

   // bit seven is ignored here; the writer keeps it zero
   logic unused_rsvd;
   assign unused_rsvd = rsvd_bit;

   function automatic logic is_cal(input logic [2:0] m);
      is_cal = (m == amsd_pkg::AMSD_CAL_IOFF) || (m == amsd_pkg::AMSD_CAL_SOFF) ||
               (m == amsd_pkg::AMSD_CAL_SGAIN);
   endfunction

   assign mode_is_cal = is_cal(mode_code);
   assign mode_is_rsvd = mode_code == `AMSD_RESERVED_MODE;

   ////////////////////////////////////////////////////////////////////
   // settle group: a switch always reloads the full wait
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         amsd_pkg::AMSD_ST_IDLE: begin
            // nothing runs before the first switch after reset
            if (chan_switch) begin
               st_d = amsd_pkg::AMSD_ST_SETTLE;
               cnt_d = dly_cycles;
            end
         end
         amsd_pkg::AMSD_ST_SETTLE: begin
            // a new switch restarts the wait in full
            if (chan_switch) begin
               cnt_d = dly_cycles;
            end else if (cnt_q == '0) begin
               st_d = amsd_pkg::AMSD_ST_RUN;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         amsd_pkg::AMSD_ST_RUN: begin
            if (chan_switch) begin
               st_d = amsd_pkg::AMSD_ST_SETTLE;
               cnt_d = dly_cycles;
            end
         end
         default: begin
            st_d = amsd_pkg::AMSD_ST_IDLE;
            cnt_d = '0;
         end
      endcase

      // flag from the next state so it lines up with the state register
      settle_d = (st_d == amsd_pkg::AMSD_ST_SETTLE);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= amsd_pkg::AMSD_ST_IDLE;
         cnt_q <= '0;
         settle_q <= 1'h0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         settle_q <= settle_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode group; a reserved code never reaches the mode register
   assign mode_take = mode_wr && !mode_is_rsvd;
   assign cal_end = cal_q && cal_done;
   assign single_end = (mode_q == amsd_pkg::AMSD_SINGLE) && conv_done && process_en;

   always_comb begin
      mode_d = mode_q;
      stop_d = stop_q;
      if (cal_end) begin
         // calibration leaves the converter idle, as single mode does
         mode_d = amsd_pkg::AMSD_STANDBY;
      end
      if (mode_take) begin
         mode_d = amsd_pkg::amsd_mode_type'(mode_code);
         stop_d = 1'h0;
      end
      if (single_end) begin
         // the stop wins over a rewrite in the same cycle
         stop_d = 1'h1;
      end

      // pins follow the mode being written
      stby_d = (mode_d == amsd_pkg::AMSD_STANDBY);
      pdn_d = (mode_d == amsd_pkg::AMSD_PDOWN);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_q <= amsd_pkg::AMSD_CONT;
         stop_q <= 1'h0;
         stby_q <= 1'h0;
         pdn_q <= 1'h0;
      end else begin
         mode_q <= mode_d;
         stop_q <= stop_d;
         stby_q <= stby_d;
         pdn_q <= pdn_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // calibration group; any other mode written, except the reserved code, aborts a running one
   always_comb begin
      cal_d = cal_q;
      start_d = 1'h0;
      kind_d = kind_q;
      // done only counts while a calibration runs
      if (cal_end) begin
         cal_d = 1'h0;
      end
      if (mode_take) begin
         cal_d = mode_is_cal;
         if (mode_is_cal) begin
            start_d = 1'h1;
            kind_d = mode_code;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cal_q <= 1'h0;
         start_q <= 1'h0;
         kind_q <= `AMSD_KIND_RST;
      end else begin
         cal_q <= cal_d;
         start_q <= start_d;
         kind_q <= kind_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   function automatic logic is_settled(input amsd_pkg::amsd_state_type s);
      is_settled = (s == amsd_pkg::AMSD_ST_RUN);
   endfunction

   // processing only in a running mode and only once settled
   always_comb begin
      case (mode_q)
         amsd_pkg::AMSD_CONT: process_en = is_settled(st_q);
         amsd_pkg::AMSD_SINGLE: process_en = is_settled(st_q) && !stop_q;
         amsd_pkg::AMSD_STANDBY: process_en = 1'h0;
         amsd_pkg::AMSD_PDOWN: process_en = 1'h0;
         // calibration owns the modulator until it reports done
         amsd_pkg::AMSD_CAL_IOFF: process_en = 1'h0;
         amsd_pkg::AMSD_CAL_SOFF: process_en = 1'h0;
         amsd_pkg::AMSD_CAL_SGAIN: process_en = 1'h0;
         amsd_pkg::AMSD_RSVD: process_en = 1'h0;
         default: process_en = 1'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // status pins straight from flops, so no decode glitches reach them
   assign settling = settle_q;
   assign cal_start = start_q;
   assign cal_kind = kind_q;
   assign cal_busy = cal_q;
   assign standby = stby_q;
   assign power_down = pdn_q;
   assign active_mode = mode_q;
endmodule

/* test/amsd_ctrl_asserts.sv */
// assertions on the mode and settling control ports
// assumes binding to amsd_ctrl by port name
`timescale 1ns/10ps
module amsd_ctrl_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] mode_code,
   input wire logic mode_wr,
   input wire logic chan_switch,
   input wire logic process_en,
   input wire logic settling,
   input wire logic cal_start,
   input wire logic cal_busy,
   input wire logic [2:0] cal_kind,
   input wire logic [2:0] active_mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   settle_go_a: assert property (chan_switch |=> settling) else $error("no settle");
   settle_hold_a: assert property (settling |-> !process_en) else $error("early run");
   mode_set_a: assert property (mode_wr && !mode_code[2]
      |=> active_mode == $past(mode_code)) else $error("mode lost");
   cal_go_a: assert property (mode_wr && mode_code[2] && mode_code != 3'h5
      |=> cal_start && cal_busy && cal_kind == $past(mode_code)) else $error("no cal");
   rsvd_keep_a: assert property (mode_wr && mode_code == 3'h5
      |=> !cal_start && $stable(active_mode)) else $error("reserved acted");
endmodule
////////////////////////////////////////
bind amsd_ctrl amsd_ctrl_asserts amsd_ctrl_asserts_inst (
   .mclk(mclk),
   .rst(rst),
   .mode_code(mode_code),
   .mode_wr(mode_wr),
   .chan_switch(chan_switch),
   .process_en(process_en),
   .settling(settling),
   .cal_start(cal_start),
   .cal_busy(cal_busy),
   .cal_kind(cal_kind),
   .active_mode(active_mode)
);

/* test/test_adc_mode_and_settling_delay.sv */
// bench for the mode and settling control
// assumes amsd_ctrl ports match the names here
`timescale 1ns/10ps
module test_adc_mode_and_settling_delay;
   logic mclk = 0, rst = 1, rsvd_bit = 0, mode_wr = 0, chan_switch = 0, conv_done = 0;
   logic cal_done = 0, process_en, settling, cal_start, cal_busy, standby, power_down;
   logic [2:0] delay_code = 3'h0, mode_code = 3'h0, cal_kind, active_mode;
   int failures = 0, n_compared = 0, cyc = 0, m_mode = 0, n;
   int us_tab[8] = '{0, 4, 16, 40, 100, 200, 500, 1000};
   int cal_log[$];
   always #20 mclk = ~mclk;
   amsd_ctrl amsd_ctrl_inst (
      .mclk(mclk),
      .rst(rst),
      .delay_code(delay_code),
      .rsvd_bit(rsvd_bit),
      .mode_code(mode_code),
      .mode_wr(mode_wr),
      .chan_switch(chan_switch),
      .conv_done(conv_done),
      .cal_done(cal_done),
      .process_en(process_en),
      .settling(settling),
      .cal_start(cal_start),
      .cal_kind(cal_kind),
      .cal_busy(cal_busy),
      .standby(standby),
      .power_down(power_down),
      .active_mode(active_mode)
   );
   ////////////////////////////////////////
   task automatic check(string w, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", w, exp, seen);
      end
   endtask
   task automatic tick(int k = 1);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic wrap_up();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // wait counted from the edge that takes the switch
   task automatic settle(logic [2:0] d, int exp);
      delay_code = d;
      chan_switch = 1;
      tick();
      chan_switch = 0;
      check("settling", settling, 1);
      for (n = 1; process_en !== 1'b1 && n < 30000; n++) tick();
      check("wait", n, exp);
   endtask
   task automatic wr_mode(logic [2:0] c);
      mode_code = c;
      rsvd_bit = 1'h0;
      mode_wr = 1;
      tick();
      mode_wr = 0;
      if (c != 3'h5) m_mode = c;
      if (c[2] && c != 3'h5) cal_log.push_back(c);
      check("mode", active_mode, m_mode);
      check("run", process_en, m_mode < 2);
      check("start", {cal_start, cal_busy}, {2{c[2] && c != 3'h5}});
      check("decode", {power_down, standby}, {m_mode == 3, m_mode == 2});
      if (c[2] && c != 3'h5) begin
         cal_done = 1;
         tick();
         cal_done = 0;
         m_mode = 2;
         check("cal end", {cal_busy, active_mode, cal_kind}, {4'h2, 3'(cal_log.pop_front())});
      end
      tick();
   endtask
   ////////////////////////////////////////
   always @(posedge mclk) if (cyc++ > 80000) begin
      failures++;
      wrap_up();
   end
   initial begin
      n = $urandom(32912);
      tick(6);
      check("reset", {process_en, settling, cal_start, cal_busy, cal_kind}, 7'h00);
      check("reset modes", {standby, power_down, active_mode}, 5'h00);
      rst = 0;
      tick();
      for (int i = 0; i < 8; i++) settle(3'(i), us_tab[i] * 25 + 2);
      // a second switch mid-wait must restart the full wait
      delay_code = 3'h1;
      chan_switch = 1;
      tick();
      chan_switch = 0;
      tick(50);
      settle(3'h1, us_tab[1] * 25 + 2);
      n = $urandom % 8;
      // random start code; the eight codes then follow in ascending order, wrapping after 7
      for (int i = 0; i < 8; i++) wr_mode(3'(i + n));
      wr_mode(3'h1);
      settle(3'h0, 2);
      conv_done = 1;
      tick();
      conv_done = 0;
      check("single", process_en, 0);
      wrap_up();
   end
endmodule
